// [bench/aerue_err_src.sv]
// Purpose: Error detector model driving one-cycle event pulses
// Assumes: Request bits sit at the flag register bit positions
// Notes:   Pulses only, so a stuck level cannot hide a missed set
`timescale 1ns/1ps
module aerue_err_src (
    input  wire        clk_i,
    input  wire [31:0] req_i,
    output reg  [31:0] err_o
);
    initial err_o = 32'h0000_0000;
    always @(posedge clk_i) err_o <= req_i;
endmodule

// [bench/aerue_logging_assertions.sv]
// Purpose: Port checks of the error logging bank
// Assumes: Flag port follows an event within two edges
// Notes:   Control register is hidden, so gated bits are left to the bench
`timescale 1ns/1ps
module aerue_checker (
    input wire        clk_i, sys_rst_i, cold_rst_i, downstream_mode_i, surprise_down_capable_i,
    input wire        avs_read_i, avs_write_i, avs_waitrequest_o,
    input wire        link_protocol_err_i, surprise_down_err_i, poisoned_err_i,
    input wire [11:0] avs_address_i,
    input wire [3:0]  avs_byteenable_i,
    input wire [31:0] avs_writedata_i, avs_readdata_o, error_flags_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (cold_rst_i || sys_rst_i);
    wire hdr = avs_read_i && !avs_waitrequest_o && avs_address_i == 12'h100;
    wire clr = avs_write_i && !avs_waitrequest_o && avs_address_i == 12'h104 && avs_byteenable_i[1];
    a_hdr_id: assert property (hdr |-> avs_readdata_o[15:0] == 16'h0001) else $error("header id wrong");
    a_hdr_ver: assert property (hdr |-> avs_readdata_o[19:16] == 4'h2) else $error("version wrong");
    a_fixed_zero: assert property ((error_flags_o & 32'hFF00_EFCE) == 0) else $error("fixed bit set");
    a_link_sets: assert property (link_protocol_err_i |-> ##[1:2] error_flags_o[4]) else $error("bit 4 unset");
    a_poison_sets: assert property (poisoned_err_i |-> ##[1:2] error_flags_o[12]) else $error("bit 12 unset");
    a_surprise_sets: assert property (surprise_down_err_i && downstream_mode_i && surprise_down_capable_i
        |-> ##[1:2] error_flags_o[5]) else $error("bit 5 unset");
    a_one_clears: assert property (clr && avs_writedata_i[12] && !poisoned_err_i |=> !error_flags_o[12])
        else $error("bit 12 kept");
    a_warm_sticky: assert property (@(posedge clk_i) disable iff (cold_rst_i) sys_rst_i |=>
        (error_flags_o & $past(error_flags_o) & 32'hFFBF_FFFF) == ($past(error_flags_o) & 32'hFFBF_FFFF))
        else $error("flag lost in reset");
    c_hdr: cover property (hdr);
    c_clear: cover property (clr);
    c_surprise: cover property (surprise_down_err_i && downstream_mode_i);
endmodule
bind aerue_logging aerue_checker chk (.clk_i, .sys_rst_i, .cold_rst_i, .downstream_mode_i,
    .surprise_down_capable_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o, .link_protocol_err_i,
    .surprise_down_err_i, .poisoned_err_i, .avs_address_i, .avs_byteenable_i, .avs_writedata_i,
    .avs_readdata_o, .error_flags_o);

// [bench/tb_aer_uncorrectable_error_logging.sv]
// Purpose: Self-checking bench of the error logging bank
// Assumes: Flags settle one edge after an event pulse, within the three that fire waits
// Notes:   Random events and clears from xorshift seeded with 97
`timescale 1ns/1ps
module tb_aer_uncorrectable_error_logging;
    localparam [11:0] UP = 12'h140, DN = 12'h150;
    localparam [31:0] HDR = 32'h0002_0001;
    logic        clk_i = 0, sys_rst_i = 1, cold_rst_i = 1, dn = 0, cap = 0, rd = 0, wr = 0, en, md;
    logic [11:0] adr = 0, ptr;
    logic [31:0] wd = 0, q, req = 0, exp = 0, r, seed = 97;
    logic [3:0]  be = 0;
    logic [1:0]  rsp;
    int          bad_count = 0, n_compared = 0;
    wire  [31:0] rdat, err, flags;
    wire  [1:0]  resp;
    wire         wt;
    always #10 clk_i = ~clk_i;
    aerue_err_src src (.clk_i(clk_i), .req_i(req), .err_o(err));
    aerue_logging #(.NXT_DEFAULT_UP(UP), .NXT_DEFAULT_DOWN(DN)) uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .cold_rst_i(cold_rst_i), .downstream_mode_i(dn), .surprise_down_capable_i(cap), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wt), .avs_response_o(resp), .link_protocol_err_i(err[4]), .surprise_down_err_i(err[5]),
        .poisoned_err_i(err[12]), .unexpected_cpl_err_i(err[16]), .rx_overflow_err_i(err[17]),
        .malformed_err_i(err[18]), .e2e_crc_err_i(err[19]), .unsupported_req_err_i(err[20]),
        .access_viol_err_i(err[21]), .internal_err_i(err[22]), .mc_blocked_err_i(err[23]),
        .obsolete_err_i(err[0]), .error_flags_o(flags));
    function logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // Settable flags on a downstream port for the given capability and control bits
    function logic [31:0] ok(input logic c, e, m);
        return 32'h003F_1011 | {8'h00, !m, e, 16'h0000, c, 5'h00};
    endfunction
    task chk(input string nm, input logic [31:0] s, e);
        n_compared++;
        if (s !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Request is held until the rising edge that samples waitrequest low, then released there
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
        @(posedge clk_i);
        rd <= !w; wr <= w; adr <= a; wd <= d; be <= b;
        do @(posedge clk_i); while (wt !== 1'b0);
        q = rdat;
        rsp = resp;
        rd <= 0; wr <= 0;
    endtask
    task look(input logic [11:0] a, input logic [31:0] e, input string nm);
        bus(0, a, 0, 4'hF);
        chk(nm, q, e);
    endtask
    task fire(input logic [31:0] v);
        @(posedge clk_i) req <= v;
        @(posedge clk_i) req <= 0;
        repeat (3) @(posedge clk_i);
    endtask
    task complete_run;
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #400000;
        bad_count++;
        complete_run;
    end
    initial begin
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 0; cold_rst_i <= 0;
        look(12'h100, {UP, HDR[19:0]}, "header up");
        cap <= 1;
        fire(32'h0000_0020);
        look(12'h104, 0, "upstream surprise");
        dn <= 1;
        repeat (3) @(posedge clk_i);
        look(12'h100, {DN, HDR[19:0]}, "header down");
        ptr = xs(seed) >> 20;
        bus(1, 12'h100, {ptr, 20'h0_0000}, 4'hC);
        dn <= 0;
        repeat (3) @(posedge clk_i);
        look(12'h100, {ptr, HDR[19:0]}, "pointer kept");
        dn <= 1;
        look(12'h1F0, 0, "unmapped");
        chk("unmapped resp", {30'h0, rsp}, 32'h3);
        for (int i = 0; i < 40; i++) begin
            seed = xs(seed);
            {md, en} = seed[1:0];
            cap <= seed[2];
            bus(1, 12'h180, {30'h0, md, en}, 4'hF);
            exp[22] &= en;
            exp[23] &= !md;
            r = xs(seed) & seed;
            fire(r);
            exp |= r & ok(seed[2], en, md);
            look(12'h104, exp, "flags");
            chk("flag port", flags, exp);
            seed = xs(seed);
            bus(1, 12'h104, seed, seed[3:0]);
            exp &= ~(seed & {{8{seed[3]}}, {8{seed[2]}}, {8{seed[1]}}, {8{seed[0]}}});
            look(12'h104, exp, "after clear");
        end
        sys_rst_i <= 1;
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 0;
        exp[22] = 0;
        look(12'h104, exp, "warm sticky");
        look(12'h100, {ptr, HDR[19:0]}, "warm pointer");
        cold_rst_i <= 1;
        repeat (5) @(posedge clk_i);
        cold_rst_i <= 0;
        look(12'h104, 0, "cold flags");
        look(12'h100, {DN, HDR[19:0]}, "cold pointer");
        fire(32'h0000_0001);
        look(12'h104, 1, "obsolete set");
        complete_run;
    end
endmodule

// [inc/aerue_map.vh]
// Purpose: Offsets, field positions, reset values for the error logging registers
// Assumes: Included by the logging bank only
// Notes:   Definitions only
`ifndef AERUE_MAP_VH
`define AERUE_MAP_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define AERUE_CAP_HDR_ADDR      12'h0100
`define AERUE_FLAGS_ADDR        12'h0104
`define AERUE_CTRL_ADDR         12'h0180
`define AERUE_ADDR_W            12

// ----------------------------------------
// Capability header fields
// ----------------------------------------
`define AERUE_CAP_ID            16'h0001
`define AERUE_CAP_VER           4'h2
`define AERUE_NXT_LSB           20
`define AERUE_NXT_W             12
`define AERUE_NXT_END           12'h000

// ----------------------------------------
// Flag bit positions
// ----------------------------------------
`define AERUE_B_OBSOLETE        0
`define AERUE_B_LINK_PROTO      4
`define AERUE_B_SURPRISE        5
`define AERUE_B_POISON          12
`define AERUE_B_FC_PROTO        13
`define AERUE_B_CPL_TIMEOUT     14
`define AERUE_B_CPL_ABORT       15
`define AERUE_B_UNEXP_CPL       16
`define AERUE_B_RX_OVERFLOW     17
`define AERUE_B_MALFORMED       18
`define AERUE_B_E2E_CRC         19
`define AERUE_B_UNSUPPORTED     20
`define AERUE_B_ACCESS_VIOL     21
`define AERUE_B_INTERNAL        22
`define AERUE_B_MC_BLOCKED      23
`define AERUE_B_ATOMIC_BLOCK    24
`define AERUE_B_PREFIX_BLOCK    25

// Bits that can ever be set, all others read zero
`define AERUE_FLAG_IMPL         32'h00FF_1031
`define AERUE_FLAG_RESET        32'h0000_0000

// ----------------------------------------
// Local control register fields
// ----------------------------------------
`define AERUE_C_INT_EN          0
`define AERUE_C_MC_DIS          1
`define AERUE_CTRL_RESET        2'h0

`endif

// [logic/aerue_logging.v]
// Purpose: Error reporting capability header and sticky uncorrectable error flags
// Assumes: One port function, Avalon-MM slave, detector pulses on clk_i
// Notes:   Flags clear on cold reset, write-one-to-clear or source disable; set wins over same-cycle clear
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "aerue_map.vh"

module aerue_logging #(
    parameter [`AERUE_NXT_W-1:0] NXT_DEFAULT_UP   = 12'h000,
    parameter [`AERUE_NXT_W-1:0] NXT_DEFAULT_DOWN = 12'h000
) (
    input  wire        clk_i,
    input  wire        sys_rst_i,
    input  wire        cold_rst_i,
    input  wire        downstream_mode_i,
    input  wire        surprise_down_capable_i,
    input  wire [11:0] avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    input  wire [3:0]  avs_byteenable_i,
    output reg  [31:0] avs_readdata_o,
    output wire        avs_waitrequest_o,
    output reg  [1:0]  avs_response_o,
    input  wire        link_protocol_err_i,
    input  wire        surprise_down_err_i,
    input  wire        poisoned_err_i,
    input  wire        unexpected_cpl_err_i,
    input  wire        rx_overflow_err_i,
    input  wire        malformed_err_i,
    input  wire        e2e_crc_err_i,
    input  wire        unsupported_req_err_i,
    input  wire        access_viol_err_i,
    input  wire        internal_err_i,
    input  wire        mc_blocked_err_i,
    input  wire        obsolete_err_i,
    output wire [31:0] error_flags_o
);

// ----------------------------------------
// Bus handshake
// ----------------------------------------
// One wait cycle per access keeps read data registered
reg         ack;
wire        req      = (avs_read_i | avs_write_i) & ~ack;
wire [31:0] be_mask  = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                        {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
wire        wr_take  = avs_write_i & ack;
wire        hit_cap  = (avs_address_i == `AERUE_CAP_HDR_ADDR);
wire        hit_flag = (avs_address_i == `AERUE_FLAGS_ADDR);
wire        hit_ctrl = (avs_address_i == `AERUE_CTRL_ADDR);

assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;

always @(posedge clk_i) begin
    if (sys_rst_i) begin
        ack <= 1'b0;
    end else begin
        ack <= req;
    end
end

// ----------------------------------------
// Local control: internal and multicast reporting
// ----------------------------------------
reg [1:0] ctrl;

always @(posedge clk_i) begin
    if (sys_rst_i) begin
        ctrl <= `AERUE_CTRL_RESET;
    end else if (wr_take && hit_ctrl && avs_byteenable_i[0]) begin
        ctrl <= avs_writedata_i[1:0];
    end
end

wire int_en = ctrl[`AERUE_C_INT_EN];
wire mc_dis = ctrl[`AERUE_C_MC_DIS];

// ----------------------------------------
// Next capability pointer
// ----------------------------------------
// Only a cold reset forgets a software value
reg  [`AERUE_NXT_W-1:0] nxt_ptr;
reg                     nxt_locked;
wire [`AERUE_NXT_W-1:0] nxt_default = downstream_mode_i ? NXT_DEFAULT_DOWN : NXT_DEFAULT_UP;
wire [31:0]             nxt_wmask   = be_mask & 32'hFFF0_0000;
wire                    nxt_wr      = wr_take & hit_cap & (|nxt_wmask);

always @(posedge clk_i) begin
    if (cold_rst_i) begin
        nxt_locked <= 1'b0;
        nxt_ptr    <= `AERUE_NXT_END;
    end else if (nxt_wr) begin
        nxt_locked <= 1'b1;
        nxt_ptr    <= (nxt_ptr & ~nxt_wmask[31:20]) | (avs_writedata_i[31:20] & nxt_wmask[31:20]);
    end else if (!nxt_locked) begin
        nxt_ptr    <= nxt_default;
    end
end

wire [31:0] cap_hdr = {nxt_ptr, `AERUE_CAP_VER, `AERUE_CAP_ID};

// ----------------------------------------
// Sticky flags
// ----------------------------------------
// Mask registers live elsewhere and have no path into these flags
reg  [31:0] flags;
reg  [31:0] set_vec;
wire [31:0] clr_vec = (wr_take && hit_flag) ? (avs_writedata_i & be_mask) : 32'h0000_0000;

always @* begin
    set_vec = 32'h0000_0000;
    set_vec[`AERUE_B_OBSOLETE]    = obsolete_err_i;
    set_vec[`AERUE_B_LINK_PROTO]  = link_protocol_err_i;
    set_vec[`AERUE_B_SURPRISE]    = surprise_down_err_i & surprise_down_capable_i & downstream_mode_i;
    set_vec[`AERUE_B_POISON]      = poisoned_err_i;
    set_vec[`AERUE_B_UNEXP_CPL]   = unexpected_cpl_err_i;
    set_vec[`AERUE_B_RX_OVERFLOW] = rx_overflow_err_i;
    set_vec[`AERUE_B_MALFORMED]   = malformed_err_i;
    set_vec[`AERUE_B_E2E_CRC]     = e2e_crc_err_i;
    set_vec[`AERUE_B_UNSUPPORTED] = unsupported_req_err_i;
    set_vec[`AERUE_B_ACCESS_VIOL] = access_viol_err_i;
    set_vec[`AERUE_B_INTERNAL]    = internal_err_i;
    set_vec[`AERUE_B_MC_BLOCKED]  = mc_blocked_err_i;
end

// Bits forced to zero: unsupported features and disabled sources
wire [31:0] live_mask = `AERUE_FLAG_IMPL
                      & ~({31'h0000_0000, ~int_en} << `AERUE_B_INTERNAL)
                      & ~({31'h0000_0000, mc_dis} << `AERUE_B_MC_BLOCKED);

// Set wins over a same-cycle clear, so no event is lost
always @(posedge clk_i) begin
    if (cold_rst_i) begin
        flags <= `AERUE_FLAG_RESET;
    end else begin
        flags <= ((flags & ~clr_vec) | set_vec) & live_mask;
    end
end

assign error_flags_o = flags;

// ----------------------------------------
// Read data and response
// ----------------------------------------
always @(posedge clk_i) begin
    if (sys_rst_i) begin
        avs_readdata_o <= 32'h0000_0000;
        avs_response_o <= 2'h0;
    end else if (req) begin
        avs_response_o <= (hit_cap | hit_flag | hit_ctrl) ? 2'h0 : 2'h3;
        if (!avs_read_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (hit_cap) begin
            avs_readdata_o <= cap_hdr;
        end else if (hit_flag) begin
            avs_readdata_o <= flags;
        end else if (hit_ctrl) begin
            avs_readdata_o <= {30'h0000_0000, ctrl};
        end else begin
            avs_readdata_o <= 32'h0000_0000;
        end
    end
end

endmodule
